//--- wtcc_consts.svh
`ifndef WTCC_CONSTS_SVH
`define WTCC_CONSTS_SVH

// Watchdog service words, written in this order
`define WTCC_SVC_ARM      8'h55
`define WTCC_SVC_FIRE     8'hAA

// Rate select fields: zero means stopped
`define WTCC_RATE_W       3
`define WTCC_RATE_OFF     3'h0

// Timer period is 2^(BASE + 2*rate) gated oscillator ticks
`define WTCC_TMR_BASE     9
`define WTCC_TMR_CW       24

// Gated oscillator tick: one pulse every OSC_DIV system clocks
`define WTCC_OSC_DIV      4

// Clock quality check window and good-oscillator edge count
`define WTCC_QC_WINDOW    50000
`define WTCC_QC_EDGES     4096

// Length of the internal reset pulse in clocks
`define WTCC_RST_CYC      16

// Reset value of the stable pin levels {osc_clk, osc_fail, ext_reset_n}
`define WTCC_PIN_RST      3'h1

`endif

//--- wtcc_pkg.sv
`include "wtcc_consts.svh"

package wtcc_pkg;

    // Watchdog control word
    typedef struct packed {
        logic                     window_en;
        logic                     pstop_en;
        logic [`WTCC_RATE_W-1:0]  rate;
    } wtcc_wdog_ctl_t;

    // Tick timer control word
    typedef struct packed {
        logic                     irq_en;
        logic                     pstop_en;
        logic [`WTCC_RATE_W-1:0]  rate;
    } wtcc_tick_ctl_t;

    // Clock monitor and PLL configuration
    typedef struct packed {
        logic monitor_en;
        logic self_clk_en;
        logic self_clk_irq_en;
        logic pll_on;
    } wtcc_clk_cfg_t;

    // Wait mode configuration bits, freely combinable
    typedef struct packed {
        logic stop_pll;
        logic stop_core;
        logic stop_system;
        logic stop_tick;
        logic stop_watchdog;
        logic reduce_amp;
    } wtcc_wait_cfg_t;

    // Wait entry and exit sequence
    typedef enum logic [2:0] {
        WTCC_RUN,
        WTCC_W_PLL_CLOCK_SELECT,
        WTCC_W_PLL,
        WTCC_W_CORE,
        WTCC_W_SYS,
        WTCC_W_ACTIVE
    } wtcc_wait_st_t;

endpackage

//--- wtcc_rate_timer.sv
`include "wtcc_consts.svh"

module wtcc_rate_timer
    import wtcc_pkg::*;
#(
    parameter int CW   = `WTCC_TMR_CW,
    parameter int BASE = `WTCC_TMR_BASE
) (
    // Clock and controls
    input  wire logic                    clk_i,
    input  wire logic                    clr_i,
    input  wire logic                    ce_i,
    input  wire logic                    restart_i,
    input  wire logic [`WTCC_RATE_W-1:0] rate_i,
    // Status
    output logic                         expire_o,
    output logic                         late_o
);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] last;
    logic [CW-1:0] quarter;

    // Period end and start of the final quarter for the chosen rate
    always_comb begin
        last    = (CW'(1) << (BASE + 2 * int'(rate_i))) - CW'(1);
        quarter = last - (last >> 2);
    end

    assign expire_o = ce_i & (cnt_ff == last);
    assign late_o   = (cnt_ff >= quarter);

    // Up counter, wraps at period end so the next period starts at once
    always_ff @(posedge clk_i) begin
        if (clr_i || restart_i) begin
            cnt_ff <= '0;
        end else if (expire_o) begin
            cnt_ff <= '0;
        end else if (ce_i) begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

endmodule

//--- wtcc_top.sv
`include "wtcc_consts.svh"

module wtcc_top
    import wtcc_pkg::*;
#(
    parameter int OSC_DIV   = `WTCC_OSC_DIV,
    parameter int QC_WINDOW = `WTCC_QC_WINDOW,
    parameter int QC_EDGES  = `WTCC_QC_EDGES,
    parameter int RST_CYC   = `WTCC_RST_CYC,
    parameter int TMR_BASE  = `WTCC_TMR_BASE
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           reset_n_i,
    // Watchdog control and service writes
    input  wire logic           wdog_ctl_wr_i,
    input  wire wtcc_wdog_ctl_t wdog_ctl_i,
    input  wire logic           svc_wr_i,
    input  wire logic [7:0]     svc_data_i,
    // Tick timer control
    input  wire logic           tick_ctl_wr_i,
    input  wire wtcc_tick_ctl_t tick_ctl_i,
    input  wire logic           tick_flag_clr_i,
    // Clock configuration
    input  wire wtcc_clk_cfg_t  clk_cfg_i,
    input  wire logic           self_clock_flag_clr_i,
    input  wire logic           pll_sel_set_i,
    input  wire logic           pll_sel_clr_i,
    input  wire logic           pseudo_stop_i,
    // Wait mode requests from the core
    input  wire logic           wait_req_i,
    input  wire wtcc_wait_cfg_t wait_cfg_i,
    input  wire logic           wake_irq_i,
    // Pins from outside the clock domain
    input  wire logic           ext_reset_n_i,
    input  wire logic           osc_fail_i,
    input  wire logic           osc_clk_i,
    // Reset outputs
    output logic                sys_reset_o,
    output logic                cm_reset_o,
    // Timer status
    output logic                wdog_en_o,
    output logic                tick_flag_o,
    output logic                tick_irq_o,
    // Self-clock status
    output logic                self_clock_mode_o,
    output logic                self_clock_flag_o,
    output logic                self_clock_irq_o,
    output logic                qc_active_o,
    // Clock controls
    output logic                pll_sel_o,
    output logic                pll_enable_o,
    output logic                voltage_regulator_keep_o,
    output logic                core_clk_en_o,
    output logic                sys_clk_en_o,
    output logic                osc_reduce_o,
    output logic                wait_active_o
);

    localparam int DW = $clog2(OSC_DIV + 1);
    localparam int QW = $clog2(QC_WINDOW + 1);
    localparam int EW = $clog2(QC_EDGES + 1);
    localparam int RW = $clog2(RST_CYC + 1);

    logic [2:0]     s1_ff;
    logic [2:0]     s2_ff;
    logic [2:0]     s3_ff;
    logic [2:0]     lvl_ff;
    logic           osc_prev_ff;
    logic [DW-1:0]  div_ff;
    logic           osc_en_ff;
    logic           rst_act_ff;
    logic           cm_rst_ff;
    logic [RW-1:0]  rst_cnt_ff;
    wtcc_wdog_ctl_t wdog_cfg_ff;
    logic           wdog_en_ff;
    logic           armed_ff;
    wtcc_tick_ctl_t tick_cfg_ff;
    logic           tick_flag_ff;
    logic           tick_irq_ff;
    logic           scm_ff;
    logic           scm_flag_ff;
    logic           scm_irq_ff;
    logic           qc_ff;
    logic [QW-1:0]  qc_win_ff;
    logic [EW-1:0]  qc_edge_ff;
    logic           pll_sel_ff;
    logic           pll_stop_ff;
    logic           pll_en_ff;
    logic           voltage_regulator_ff;
    logic           core_en_ff;
    logic           sys_en_ff;
    logic           reduce_ff;
    logic           wait_act_ff;
    wtcc_wait_st_t  state_ff;

    logic kill;
    logic ext_rst;
    logic fail_lvl;
    logic osc_rise;
    logic wd_run;
    logic wd_expire;
    logic wd_late;
    logic wd_fault;
    logic svc_word;
    logic svc_early;
    logic svc_ok;
    logic tick_run;
    logic tick_expire;
    logic cm_fault;
    logic scm_entry;
    logic wake;

    // Pins pass three flops; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s1_ff  <= `WTCC_PIN_RST;
            s2_ff  <= `WTCC_PIN_RST;
            s3_ff  <= `WTCC_PIN_RST;
            lvl_ff <= `WTCC_PIN_RST;
        end else begin
            s1_ff  <= {osc_clk_i, osc_fail_i, ext_reset_n_i};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
        end
    end

    assign ext_rst  = !lvl_ff[0];
    assign fail_lvl = lvl_ff[1] & clk_cfg_i.monitor_en;
    assign osc_rise = lvl_ff[2] & !osc_prev_ff;

    // Internal reset clears all control state except the quality checker, self-clock mode and the self-clock flag and interrupt
    assign kill = !reset_n_i | rst_act_ff;

    // Gated oscillator tick; a divider keeps the design on one clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            div_ff      <= '0;
            osc_en_ff   <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= lvl_ff[2];
            osc_en_ff   <= (div_ff == DW'(OSC_DIV - 1));
            if (div_ff == DW'(OSC_DIV - 1)) begin
                div_ff <= '0;
            end else begin
                div_ff <= div_ff + DW'(1);
            end
        end
    end

    // Reset generator; an external reset also restores all settings
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rst_act_ff <= 1'b0;
            cm_rst_ff  <= 1'b0;
            rst_cnt_ff <= '0;
        end else if (ext_rst || wd_fault || cm_fault) begin
            rst_act_ff <= 1'b1;
            cm_rst_ff  <= cm_fault & !ext_rst;
            rst_cnt_ff <= RW'(RST_CYC - 1);
        end else if (rst_act_ff) begin
            if (rst_cnt_ff == '0) begin
                rst_act_ff <= 1'b0;
                cm_rst_ff  <= 1'b0;
            end else begin
                rst_cnt_ff <= rst_cnt_ff - RW'(1);
            end
        end
    end

    // Watchdog control: off after reset, on by a nonzero rate write
    always_ff @(posedge clk_i) begin
        if (kill) begin
            wdog_cfg_ff <= '0;
            wdog_en_ff  <= 1'b0;
        end else if (wdog_ctl_wr_i) begin
            wdog_cfg_ff <= wdog_ctl_i;
            wdog_en_ff  <= (wdog_ctl_i.rate != `WTCC_RATE_OFF);
        end
    end

    // Counts gated ticks unless frozen by pseudo-stop or wait
    assign wd_run = wdog_en_ff & osc_en_ff
                  & !(pseudo_stop_i & !wdog_cfg_ff.pstop_en)
                  & !(wait_act_ff & wait_cfg_i.stop_watchdog);

    wtcc_rate_timer #(
        .CW   (`WTCC_TMR_CW),
        .BASE (TMR_BASE)
    ) u_wdog_tmr (
        .clk_i     (clk_i),
        .clr_i     (kill),
        .ce_i      (wd_run),
        .restart_i (svc_ok | wdog_ctl_wr_i),
        .rate_i    (wdog_cfg_ff.rate),
        .expire_o  (wd_expire),
        .late_o    (wd_late)
    );

    // Service decode; a write outside the window is itself a fault
    assign svc_word  = (svc_data_i == `WTCC_SVC_ARM)
                     | (svc_data_i == `WTCC_SVC_FIRE);
    assign svc_early = wdog_cfg_ff.window_en & !wd_late;
    assign svc_ok    = wdog_en_ff & svc_wr_i & armed_ff & !svc_early
                     & (svc_data_i == `WTCC_SVC_FIRE);
    assign wd_fault  = wdog_en_ff
                     & ((wd_expire & wd_run)
                     | (svc_wr_i & !svc_word)
                     | (svc_wr_i & svc_early));

    // First word arms; any other write disarms
    always_ff @(posedge clk_i) begin
        if (kill) begin
            armed_ff <= 1'b0;
        end else if (wdog_en_ff && svc_wr_i) begin
            armed_ff <= (svc_data_i == `WTCC_SVC_ARM);
        end
    end

    // Tick control; every write restarts the period
    always_ff @(posedge clk_i) begin
        if (kill) begin
            tick_cfg_ff <= '0;
        end else if (tick_ctl_wr_i) begin
            tick_cfg_ff <= tick_ctl_i;
        end
    end

    assign tick_run = (tick_cfg_ff.rate != `WTCC_RATE_OFF) & osc_en_ff
                    & !(pseudo_stop_i & !tick_cfg_ff.pstop_en)
                    & !(wait_act_ff & wait_cfg_i.stop_tick);

    wtcc_rate_timer #(
        .CW   (`WTCC_TMR_CW),
        .BASE (TMR_BASE)
    ) u_tick_tmr (
        .clk_i     (clk_i),
        .clr_i     (kill),
        .ce_i      (tick_run),
        .restart_i (tick_ctl_wr_i),
        .rate_i    (tick_cfg_ff.rate),
        .expire_o  (tick_expire),
        .late_o    ()
    );

    // Tick flag: a period end in the clearing cycle still sets it
    always_ff @(posedge clk_i) begin
        if (kill) begin
            tick_flag_ff <= 1'b0;
            tick_irq_ff  <= 1'b0;
        end else begin
            if (tick_expire) begin
                tick_flag_ff <= 1'b1;
            end else if (tick_flag_clr_i) begin
                tick_flag_ff <= 1'b0;
            end
            tick_irq_ff <= tick_flag_ff & tick_cfg_ff.irq_en;
        end
    end

    // Clock loss: reset without self-clock, else enter self-clock mode
    assign cm_fault  = fail_lvl & !clk_cfg_i.self_clk_en & !rst_act_ff;
    assign scm_entry = fail_lvl & clk_cfg_i.self_clk_en & !scm_ff;

    // Quality checker survives internal resets so checking goes on
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            scm_ff     <= 1'b0;
            qc_ff      <= 1'b0;
            qc_win_ff  <= '0;
            qc_edge_ff <= '0;
        end else if (scm_entry) begin
            scm_ff     <= 1'b1;
            qc_ff      <= 1'b1;
            qc_win_ff  <= '0;
            qc_edge_ff <= '0;
        end else if (qc_ff) begin
            if (osc_rise && qc_edge_ff == EW'(QC_EDGES - 1)) begin
                qc_ff  <= 1'b0;
                scm_ff <= 1'b0;
            end else if (qc_win_ff == QW'(QC_WINDOW - 1)) begin
                qc_win_ff  <= '0;
                qc_edge_ff <= '0;
            end else begin
                qc_win_ff  <= qc_win_ff + QW'(1);
                qc_edge_ff <= qc_edge_ff + EW'(osc_rise);
            end
        end
    end

    // Self-clock flag: entry wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            scm_flag_ff <= 1'b0;
            scm_irq_ff  <= 1'b0;
        end else begin
            if (scm_entry) begin
                scm_flag_ff <= 1'b1;
            end else if (self_clock_flag_clr_i) begin
                scm_flag_ff <= 1'b0;
            end
            scm_irq_ff <= scm_flag_ff & clk_cfg_i.self_clk_irq_en;
        end
    end

    // PLL select: hardware clears take priority over software sets
    always_ff @(posedge clk_i) begin
        if (kill) begin
            pll_sel_ff <= 1'b0;
        end else if (scm_entry) begin
            pll_sel_ff <= 1'b0;
        end else if (state_ff == WTCC_W_PLL_CLOCK_SELECT && wait_cfg_i.stop_pll) begin
            pll_sel_ff <= 1'b0;
        end else if (pll_sel_clr_i) begin
            pll_sel_ff <= 1'b0;
        end else if (pll_sel_set_i && !scm_ff) begin
            pll_sel_ff <= 1'b1;
        end
    end

    // Wake on any interrupt; self-clock wakes only when its enable is set
    assign wake = wake_irq_i | tick_irq_ff | scm_irq_ff;

    // Wait sequence: one gating step per clock, reversed at once on wake
    always_ff @(posedge clk_i) begin
        if (kill) begin
            state_ff    <= WTCC_RUN;
            pll_stop_ff <= 1'b0;
            core_en_ff  <= 1'b1;
            sys_en_ff   <= 1'b1;
            wait_act_ff <= 1'b0;
        end else if (state_ff != WTCC_RUN && wake) begin
            state_ff    <= WTCC_RUN;
            pll_stop_ff <= 1'b0;
            core_en_ff  <= 1'b1;
            sys_en_ff   <= 1'b1;
            wait_act_ff <= 1'b0;
        end else begin
            case (state_ff)
                WTCC_RUN: begin
                    if (wait_req_i) begin
                        state_ff <= WTCC_W_PLL_CLOCK_SELECT;
                    end
                end
                WTCC_W_PLL_CLOCK_SELECT: begin
                    state_ff <= WTCC_W_PLL;
                end
                WTCC_W_PLL: begin
                    pll_stop_ff <= wait_cfg_i.stop_pll;
                    state_ff    <= WTCC_W_CORE;
                end
                WTCC_W_CORE: begin
                    core_en_ff <= !(wait_cfg_i.stop_core
                                  | wait_cfg_i.stop_system);
                    state_ff   <= WTCC_W_SYS;
                end
                WTCC_W_SYS: begin
                    sys_en_ff   <= !wait_cfg_i.stop_system;
                    wait_act_ff <= 1'b1;
                    state_ff    <= WTCC_W_ACTIVE;
                end
                default: begin
                    state_ff <= WTCC_W_ACTIVE;
                end
            endcase
        end
    end

    // PLL and regulator stay up while self-clock or a check runs, but drop during an internal reset
    always_ff @(posedge clk_i) begin
        if (kill) begin
            pll_en_ff <= 1'b0;
            voltage_regulator_ff   <= 1'b0;
            reduce_ff <= 1'b0;
        end else begin
            pll_en_ff <= scm_ff | qc_ff
                       | (clk_cfg_i.pll_on & !pll_stop_ff);
            voltage_regulator_ff   <= scm_ff | qc_ff;
            reduce_ff <= wait_act_ff & wait_cfg_i.reduce_amp;
        end
    end

    // Outputs, each from a flop
    assign sys_reset_o       = rst_act_ff;
    assign cm_reset_o        = cm_rst_ff;
    assign wdog_en_o         = wdog_en_ff;
    assign tick_flag_o       = tick_flag_ff;
    assign tick_irq_o        = tick_irq_ff;
    assign self_clock_mode_o = scm_ff;
    assign self_clock_flag_o = scm_flag_ff;
    assign self_clock_irq_o  = scm_irq_ff;
    assign qc_active_o       = qc_ff;
    assign pll_sel_o         = pll_sel_ff;
    assign pll_enable_o      = pll_en_ff;
    assign voltage_regulator_keep_o       = voltage_regulator_ff;
    assign core_clk_en_o     = core_en_ff;
    assign sys_clk_en_o      = sys_en_ff;
    assign osc_reduce_o      = reduce_ff;
    assign wait_active_o     = wait_act_ff;

endmodule

//--- wtcc_osc_model.sv
module wtcc_osc_model (
    // Run control from the bench
    input  wire logic run_i,
    // Oscillator pins
    output logic      osc_clk_o,
    output logic      osc_fail_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Crystal stand-in; a lost crystal freezes at its last level
    initial begin
        osc_clk_o = 1'b0;
        forever begin
            #103;
            if (run_i) begin
                osc_clk_o = ~osc_clk_o;
            end
        end
    end

    // Flags a missing crystal at once
    assign osc_fail_o = !run_i;
endmodule

//--- wtcc_top_monitor.sv
module wtcc_top_chk
    import wtcc_pkg::*;
(
    // Clock and reset
    input wire logic           clk_i,
    input wire logic           reset_n_i,
    // Inputs that cause behaviour
    input wire logic           svc_wr_i,
    input wire logic [7:0]     svc_data_i,
    input wire logic           wdog_ctl_wr_i,
    input wire wtcc_wdog_ctl_t wdog_ctl_i,
    input wire logic           tick_flag_clr_i,
    input wire wtcc_clk_cfg_t  clk_cfg_i,
    input wire logic           wake_irq_i,
    // Outputs under watch
    input wire logic           sys_reset_o,
    input wire logic           cm_reset_o,
    input wire logic           wdog_en_o,
    input wire logic           tick_flag_o,
    input wire logic           tick_irq_o,
    input wire logic           self_clock_mode_o,
    input wire logic           self_clock_flag_o,
    input wire logic           self_clock_irq_o,
    input wire logic           pll_sel_o,
    input wire logic           pll_enable_o,
    input wire logic           wait_active_o,
    input wire logic           sys_clk_en_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // One clock domain
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_rst_wdog_off: assert property (disable iff (1'b0)
        !reset_n_i |=> !wdog_en_o && !tick_flag_o) else $error("reset");
    chk_wdog_enable: assert property (wdog_ctl_wr_i
        && wdog_ctl_i.rate != 3'h0 |=> wdog_en_o || sys_reset_o)
        else $error("wdog enable");
    chk_wdog_rate_off: assert property (wdog_ctl_wr_i
        && wdog_ctl_i.rate == 3'h0 |=> !wdog_en_o) else $error("rate off");
    chk_bad_service: assert property (svc_wr_i && wdog_en_o
        && svc_data_i != 8'h55 && svc_data_i != 8'hAA |=> sys_reset_o)
        else $error("bad service");
    chk_tick_flag_hold: assert property (tick_flag_o
        && !tick_flag_clr_i |=> tick_flag_o || sys_reset_o)
        else $error("tick flag lost");
    chk_tick_irq_cause: assert property ($rose(tick_irq_o)
        |-> $past(tick_flag_o)) else $error("tick irq");
    chk_scm_cause: assert property ($rose(self_clock_mode_o)
        |-> ($past(clk_cfg_i) & 4'hC) == 4'hC) else $error("scm cause");
    chk_scm_entry: assert property ($rose(self_clock_mode_o)
        |-> !pll_sel_o && self_clock_flag_o) else $error("scm entry");
    chk_cm_with_rst: assert property (cm_reset_o
        |-> sys_reset_o) else $error("cm reset");
    chk_scm_irq_cause: assert property ($rose(self_clock_irq_o)
        |-> $past(self_clock_flag_o)) else $error("scm irq");
    chk_wait_sys_last: assert property ($fell(sys_clk_en_o)
        |-> wait_active_o) else $error("wait order");
    chk_wake_run: assert property (wait_active_o && wake_irq_i
        |-> ##[1:2] !wait_active_o) else $error("wake");
    chk_scm_pll_on: assert property (self_clock_mode_o
        |=> pll_enable_o) else $error("scm pll");
endmodule

bind wtcc_top wtcc_top_chk wtcc_top_chk_inst (.*);

//--- wtcc_top_tb_top.sv
module wtcc_top_tb_top
    import wtcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OD = 2;
    localparam int TB = 1;

    // Stimulus, idle at time zero
    logic clk_i = 1'b0, reset_n_i = 1'b0, wdog_ctl_wr_i = 1'b0;
    logic svc_wr_i = 1'b0, tick_ctl_wr_i = 1'b0, tick_flag_clr_i = 1'b0;
    logic self_clock_flag_clr_i = 1'b0, pll_sel_set_i = 1'b0;
    logic pseudo_stop_i = 1'b0, wait_req_i = 1'b0, wake_irq_i = 1'b0;
    logic pll_sel_clr_i = 1'b0;
    logic ext_reset_n_i = 1'b1, osc_run = 1'b1;
    logic [7:0]     svc_data_i = 8'h00;
    wtcc_wdog_ctl_t wdog_ctl_i = '0;
    wtcc_tick_ctl_t tick_ctl_i = '0;
    wtcc_clk_cfg_t  clk_cfg_i = '0;
    wtcc_wait_cfg_t wait_cfg_i = '0;
    logic osc_fail_i, osc_clk_i, sys_reset_o, cm_reset_o, wdog_en_o;
    logic tick_flag_o, tick_irq_o, self_clock_mode_o, self_clock_flag_o;
    logic self_clock_irq_o, qc_active_o, pll_sel_o, pll_enable_o;
    logic voltage_regulator_keep_o, core_clk_en_o, sys_clk_en_o, osc_reduce_o;
    logic wait_active_o;
    int   err_count = 0;
    int   check_count = 0;

    // Short counts keep the run brief
    wtcc_top #(.OSC_DIV(OD), .QC_WINDOW(64), .QC_EDGES(8),
        .TMR_BASE(TB)) wtcc_top_inst (.*);

    wtcc_osc_model wtcc_osc_model_inst (.run_i(osc_run),
        .osc_clk_o(osc_clk_i), .osc_fail_o(osc_fail_i));

    // 25 MHz system clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Period in system clocks for a rate code
    function automatic int per(input int r);
        return OD * (2 ** (TB + 2 * r));
    endfunction

    // Gated tick phase is unknown: allow slack
    function automatic logic near(input int k, input int e);
        return k >= e - 4 && k <= e + 4;
    endfunction

    function automatic logic pick(input int s);
        case (s)
            0: return sys_reset_o;
            1: return tick_flag_o;
            2: return self_clock_mode_o;
            3: return wait_active_o;
            4: return !self_clock_mode_o;
            default: return !sys_reset_o;
        endcase
    endfunction

    // Bounded wait; k equals n on timeout
    task automatic wt(input int s, input int n, output int k);
        for (k = 0; k < n; k++) begin
            if (pick(s) === 1'b1) break;
            cyc(1);
        end
    endtask

    task automatic need(input int s, input int n);
        int k;
        wt(s, n, k);
        if (k == n) begin
            err_count++;
            report_and_stop();
        end
    endtask

    task automatic wdog(input logic [4:0] c);
        wdog_ctl_i = c;
        wdog_ctl_wr_i = 1'b1;
        cyc(1);
        wdog_ctl_wr_i = 1'b0;
        cyc(1);
    endtask

    task automatic tick(input logic [4:0] c);
        tick_ctl_i = c;
        tick_ctl_wr_i = 1'b1;
        cyc(1);
        tick_ctl_wr_i = 1'b0;
        cyc(1);
    endtask

    task automatic svc(input logic [7:0] d);
        svc_data_i = d;
        svc_wr_i = 1'b1;
        cyc(1);
        svc_wr_i = 1'b0;
    endtask

    // Both words, strobe held
    task automatic svc2();
        svc_data_i = 8'h55;
        svc_wr_i = 1'b1;
        cyc(1);
        svc_data_i = 8'hAA;
        cyc(1);
        svc_wr_i = 1'b0;
    endtask

    task automatic clr();
        tick_flag_clr_i = 1'b1;
        cyc(1);
        tick_flag_clr_i = 1'b0;
    endtask

    task automatic pulse_req(input logic pll);
        pll_sel_set_i = pll;
        wait_req_i = !pll;
        cyc(1);
        pll_sel_set_i = 1'b0;
        wait_req_i = 1'b0;
        cyc(1);
    endtask

    // Main sequence
    initial begin
        int k;
        int r;
        cyc(4);
        reset_n_i = 1'b1;
        cyc(1);
        chk({wdog_en_o, tick_flag_o, core_clk_en_o}, 3'b001);
        for (r = 1; r < 4; r++) begin
            wdog(5'(r));
            chk(wdog_en_o, 1'b1);
            wt(0, 600, k);
            chk(near(k, per(r)), 1'b1);
            need(5, 40);
        end
        wdog(5'h02);
        repeat (4) begin
            cyc(30);
            svc2();
        end
        chk(wdog_en_o, 1'b1);
        wt(0, 200, k);
        chk(near(k, per(2)), 1'b1);
        need(5, 40);
        wdog(5'h02);
        repeat (3) begin
            cyc(25);
            svc(8'hAA);
        end
        chk(wdog_en_o, 1'b0);
        need(5, 40);
        wdog(5'h03);
        svc(8'h12);
        wt(0, 4, k);
        chk(16'(k), 16'h0);
        need(5, 40);
        wdog(5'h12);
        cyc(8);
        svc(8'h55);
        wt(0, 4, k);
        chk(16'(k), 16'h0);
        need(5, 40);
        wdog(5'h12);
        cyc(54);
        svc2();
        cyc(4);
        chk({sys_reset_o, wdog_en_o}, 2'b01);
        wdog(5'h00);
        chk(wdog_en_o, 1'b0);
        wt(0, 300, k);
        chk(16'(k), 16'(300));
        pseudo_stop_i = 1'b1;
        wdog(5'h01);
        wt(0, 60, k);
        chk(16'(k), 16'(60));
        wdog(5'h09);
        wt(0, 60, k);
        chk(near(k, per(1)), 1'b1);
        need(5, 40);
        tick(5'h01);
        clr();
        wt(1, 60, k);
        chk(16'(k), 16'(60));
        tick(5'h09);
        wt(1, 60, k);
        chk(near(k, per(1)), 1'b1);
        pseudo_stop_i = 1'b0;
        tick(5'h11);
        clr();
        wt(1, 60, k);
        chk(near(k, per(1)), 1'b1);
        cyc(2);
        chk(tick_irq_o, 1'b1);
        clr();
        wt(1, 60, k);
        chk(near(k, per(1) - 3), 1'b1);
        tick(5'h01);
        cyc(10);
        tick(5'h01);
        clr();
        wt(1, 60, k);
        chk(near(k, per(1) - 2), 1'b1);
        cyc(2);
        chk(tick_irq_o, 1'b0);
        tick(5'h00);
        clr();
        wt(1, 100, k);
        chk(16'(k), 16'(100));
        clk_cfg_i = 4'b1101;
        pulse_req(1'b1);
        chk(pll_sel_o, 1'b1);
        osc_run = 1'b0;
        wt(2, 10, k);
        cyc(2);
        chk({self_clock_flag_o, pll_sel_o, pll_enable_o,
            self_clock_irq_o}, 4'b1010);
        osc_run = 1'b1;
        wt(4, 400, k);
        cyc(2);
        chk({k < 400, qc_active_o}, 2'b10);
        self_clock_flag_clr_i = 1'b1;
        clk_cfg_i = 4'b1001;
        cyc(20);
        self_clock_flag_clr_i = 1'b0;
        osc_run = 1'b0;
        wt(0, 10, k);
        chk({cm_reset_o, self_clock_mode_o}, 2'b10);
        osc_run = 1'b1;
        need(5, 60);
        clk_cfg_i = 4'b0001;
        pulse_req(1'b1);
        wait_cfg_i = 6'b111000;
        pulse_req(1'b0);
        wt(3, 10, k);
        chk({pll_sel_o, pll_enable_o, core_clk_en_o,
            sys_clk_en_o}, 4'h0);
        wake_irq_i = 1'b1;
        cyc(2);
        wake_irq_i = 1'b0;
        chk({wait_active_o, pll_sel_o, sys_clk_en_o}, 3'b001);
        wait_cfg_i = 6'b000011;
        pulse_req(1'b0);
        wt(3, 10, k);
        cyc(1);
        chk({osc_reduce_o, core_clk_en_o, sys_clk_en_o}, 3'h7);
        ext_reset_n_i = 1'b0;
        wt(0, 10, k);
        ext_reset_n_i = 1'b1;
        cyc(1);
        chk({sys_reset_o, wait_active_o, osc_reduce_o}, 3'b100);
        need(5, 40);
        clk_cfg_i = 4'b1100;
        wait_cfg_i = 6'b000000;
        pulse_req(1'b0);
        wt(3, 10, k);
        osc_run = 1'b0;
        wt(2, 10, k);
        cyc(2);
        chk({wait_active_o, self_clock_flag_o, pll_enable_o,
            voltage_regulator_keep_o}, 4'hF);
        osc_run = 1'b1;
        wt(4, 400, k);
        wake_irq_i = 1'b1;
        cyc(2);
        wake_irq_i = 1'b0;
        chk(wait_active_o, 1'b0);
        report_and_stop();
    end
endmodule
